// File: bench/cidr_core_model.sv
`timescale 1ns/100ps
`default_nettype none
module cidr_core_model (
	input wire logic mclk,
	output logic xfer_valid = 1'b0,
	output logic xfer_read = 1'b0,
	output logic xfer_privileged = 1'b0,
	output logic xfer_is_reg = 1'b0,
	output logic [3:0] xfer_major_reg = 4'h0,
	output logic [3:0] minor_register_selector,
	output logic [2:0] xfer_op2 = 3'h0
);
	assign minor_register_selector = 4'h0;
	task xfer(input logic [2:0] op, input logic [3:0] mj, input logic [2:0] k);
		@(negedge mclk);
		{xfer_is_reg, xfer_read, xfer_privileged, xfer_major_reg, xfer_op2} = {k, mj, op};
		xfer_valid = 1'b1;
		@(negedge mclk);
		xfer_valid = 1'b0;
		xfer_op2 = ~op;
	endtask
endmodule
`default_nettype wire

// File: bench/cidr_regs_sva.sv
`timescale 1ns/100ps
`default_nettype none
module cidr_regs_chk (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic xfer_valid,
	input wire logic xfer_read,
	input wire logic xfer_privileged,
	input wire logic xfer_is_reg,
	input wire logic [3:0] xfer_major_reg,
	input wire logic [2:0] xfer_op2,
	input wire logic itcm_present,
	input wire logic dtcm_present,
	input wire logic rdata_valid_r,
	input wire logic [31:0] rdata,
	input wire logic undef_r
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!nrst);
	wire rd = xfer_valid && xfer_major_reg == 4'h0 && xfer_is_reg && xfer_read && xfer_privileged;
	wire bad = xfer_valid && xfer_major_reg == 4'h0 && !(xfer_is_reg && xfer_privileged);
	sequence s_ans; rdata_valid_r && !undef_r; endsequence
	sequence s_cache; rd && xfer_op2 == 3'h1; endsequence
	read_ans_a: assert property (rd |=> s_ans) else $error("no answer");
	bad_undef_a: assert property (bad |=> undef_r) else $error("no undef");
	quiet_a: assert property (!(rd || bad) |=> !rdata_valid_r && !undef_r)
		else $error("spurious");
	hold_a: assert property (!rd |=> $stable(rdata)) else $error("moved");
	id_word_a: assert property (rd && !(xfer_op2 inside {3'h1, 3'h2})
		|=> rdata == 32'h5a12_1233) else $error("id");
	cache_fix_a: assert property (s_cache |=> (rdata & 32'hffc3_fc3f) == 32'h1d01_2012)
		else $error("cache");
	cache_size_a: assert property (s_cache |=> rdata[21:18] == 4'h4 && rdata[9:6] == 4'h5)
		else $error("size");
	mem_stat_a: assert property (rd && xfer_op2 == 3'h2
		|=> rdata == {15'h0, $past(itcm_present), 15'h0, $past(dtcm_present)}) else $error("mem");
endmodule
bind cidr_regs cidr_regs_chk i_chk (
	.mclk(mclk),
	.nrst(nrst),
	.xfer_valid(xfer_valid),
	.xfer_read(xfer_read),
	.xfer_privileged(xfer_privileged),
	.xfer_is_reg(xfer_is_reg),
	.xfer_major_reg(xfer_major_reg),
	.xfer_op2(xfer_op2),
	.itcm_present(itcm_present),
	.dtcm_present(dtcm_present),
	.rdata_valid_r(rdata_valid_r),
	.rdata(rdata),
	.undef_r(undef_r)
);
`default_nettype wire

// File: bench/test_coproc_id_cache_type_regs.sv
`timescale 1ns/100ps
`default_nettype none
module test_coproc_id_cache_type_regs;
	logic mclk = 1'b0, nrst = 1'b0, itcm_present = 1'b0, dtcm_present = 1'b0;
	wire xfer_valid, xfer_read, xfer_privileged, xfer_is_reg, rdata_valid_r, undef_r;
	wire [3:0] xfer_major_reg, minor_register_selector;
	wire [2:0] xfer_op2;
	wire [31:0] rdata;
	logic [33:0] e = 34'h0;
	int n_mismatch = 0, check_count = 0;
	cidr_regs i_dut (
		.mclk(mclk),
		.nrst(nrst),
		.xfer_valid(xfer_valid),
		.xfer_read(xfer_read),
		.xfer_privileged(xfer_privileged),
		.xfer_is_reg(xfer_is_reg),
		.xfer_major_reg(xfer_major_reg),
		.minor_register_selector(minor_register_selector),
		.xfer_op2(xfer_op2),
		.itcm_present(itcm_present),
		.dtcm_present(dtcm_present),
		.rdata_valid_r(rdata_valid_r),
		.rdata(rdata),
		.undef_r(undef_r)
	);
	cidr_core_model i_core (
		.mclk(mclk),
		.xfer_valid(xfer_valid),
		.xfer_read(xfer_read),
		.xfer_privileged(xfer_privileged),
		.xfer_is_reg(xfer_is_reg),
		.xfer_major_reg(xfer_major_reg),
		.minor_register_selector(minor_register_selector),
		.xfer_op2(xfer_op2)
	);
	initial forever #5 mclk = ~mclk;
	function logic [31:0] exp_w(input logic [2:0] op);
		return op == 3'h1 ? 32'h1d11_2152 : op == 3'h2 ?
			{15'h0, itcm_present, 15'h0, dtcm_present} : 32'h5a12_1233;
	endfunction
	task run(input logic [2:0] op, input logic [3:0] mj, input logic [2:0] k);
		{itcm_present, dtcm_present} = 2'($urandom);
		i_core.xfer(op, mj, k);
		e[33:32] = {mj == 4'h0 && k == 3'h7, mj == 4'h0 && !(k[2] && k[0])};
		if (e[33]) e[31:0] = exp_w(op);
		check_count++;
		if ({rdata_valid_r, undef_r, rdata} !== e) begin
			n_mismatch++;
			$display("CHECK FAILED %0t %h %h", $time, {rdata_valid_r, undef_r, rdata}, e);
		end
	endtask
	task stop_test;
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial begin
		#20000;
		n_mismatch++;
		stop_test;
	end
	initial begin
		void'($urandom(34939));
		repeat (10) @(negedge mclk);
		nrst = 1'b1;
		for (int i = 0; i < 8; i++) run(3'(i), 4'h0, 3'h7);
		run(3'h1, 4'h0, 3'h6);
		run(3'h1, 4'h0, 3'h3);
		run(3'h0, 4'h0, 3'h5);
		$display("test corners done");
		nrst = 1'b0;
		repeat (2) @(negedge mclk);
		nrst = 1'b1;
		e = 34'h0;
		run(3'h0, 4'h1, 3'h7);
		$display("test reset done");
		for (int i = 0; i < 60; i++) run(3'($urandom), 4'($urandom % 2), 3'($urandom));
		$display("test random done");
		stop_test;
	end
endmodule
`default_nettype wire

// File: design/cidr_defs.vh
`ifndef CIDR_DEFS_VH
`define CIDR_DEFS_VH

// Field positions of the identity word
`define CIDR_ID_IMPL_LSB 24
`define CIDR_ID_VAR_LSB 20
`define CIDR_ID_ARCH_LSB 16
`define CIDR_ID_PART_LSB 4
`define CIDR_ID_REV_LSB 0

// Secondary opcode selections
`define CIDR_OP2_CACHE 3'h1
`define CIDR_OP2_MEMST 3'h2

// Location of the identification group
`define CIDR_LOC_ZERO 4'h0

// Cache geometry word constants
`define CIDR_CTYPE 4'he
`define CIDR_SEPARATE 1'b1
`define CIDR_ASSOC_4WAY 3'h2
`define CIDR_MULT_PRESENT 1'b0
`define CIDR_LEN_8WORD 2'h2
`define CIDR_DESC_RSVD 2'h0
`define CIDR_TOP_RSVD 3'h0

// Size ladder: 4KB gives code 3
`define CIDR_SIZE_BASE_KB 4
`define CIDR_SIZE_BASE_CODE 4'h3
`define CIDR_SIZE_MAX_KB 128

// Memory status word bit positions
`define CIDR_MEMST_DPRES 0
`define CIDR_MEMST_IPRES 16

`define CIDR_ZERO_WORD 32'h0000_0000

`endif

// File: design/cidr_regs.v
// Functional notes
// - Secondary opcode picks identity, cache, memory status
// - Other opcode values return identity word
// - Identity word is constant read-only
// - Identity fields: implementer, variant, architecture, part, revision
// - Revision field follows built layout revision
// - Cache type bits 28:25 read 1110
// - Bit 24 shows separate caches
// - Descriptors share layout, top bits zero
// - Multiplier bits read zero, caches present
// - Size codes placed per cache capacity
// - Size ladder 4KB code 3 to 128KB
// - Associativity reads four-way code
// - Line length reads eight-word code
// - Memory status word read-only, reports presence
// - Only privileged read transfers accepted here
`timescale 1ns/100ps
`default_nettype none

`include "cidr_defs.vh"

module cidr_regs #(
	parameter [7:0] IMPL_CODE = 8'h5a, // Arbitrary value
	parameter [3:0] VARIANT = 4'h1, // Arbitrary value
	parameter [3:0] ARCH_CODE = 4'h2, // Arbitrary value
	parameter [11:0] PART_NUM = 12'h123, // Arbitrary value
	parameter [3:0] LAYOUT_REV = 4'h3, // Arbitrary value
	parameter DCACHE_KB = 8,
	parameter ICACHE_KB = 16
) (
	input wire mclk,
	input wire nrst,
	input wire xfer_valid,
	input wire xfer_read,
	input wire xfer_privileged,
	input wire xfer_is_reg,
	input wire [3:0] xfer_major_reg,
	input wire [3:0] minor_register_selector,
	input wire [2:0] xfer_op2,
	input wire itcm_present,
	input wire dtcm_present,
	output reg rdata_valid_r,
	output wire [31:0] rdata,
	output reg undef_r
);

	// ------------------------------------------------------------
	// Capacity ladder and field helpers
	// ------------------------------------------------------------
	// Capacities outside the ladder clamp to its end points
	function [3:0] size_code;
		input integer kb;
		integer k;
		integer c;
		begin
			c = 0;
			k = `CIDR_SIZE_BASE_KB;
			while (k < kb && k < `CIDR_SIZE_MAX_KB) begin
				k = k * 2;
				c = c + 1;
			end
			size_code = `CIDR_SIZE_BASE_CODE + c[3:0];
		end
	endfunction

	function [11:0] descriptor;
		input [3:0] sz;
		begin
			descriptor = {`CIDR_DESC_RSVD, sz, `CIDR_ASSOC_4WAY,
				`CIDR_MULT_PRESENT, `CIDR_LEN_8WORD};
		end
	endfunction

	// Zero-extends a field of up to twelve bits and moves it into place
	function [31:0] place_field;
		input [11:0] value;
		input integer lsb;
		begin
			place_field = {20'h0_0000, value} << lsb;
		end
	endfunction

	localparam [3:0] DSIZE = size_code(DCACHE_KB);
	localparam [3:0] ISIZE = size_code(ICACHE_KB);

	// ------------------------------------------------------------
	// Identity word
	// ------------------------------------------------------------
	wire [31:0] id_impl_f;
	wire [31:0] id_var_f;
	wire [31:0] id_arch_f;
	wire [31:0] id_part_f;
	wire [31:0] id_rev_f;
	wire [31:0] id_word;

	assign id_impl_f = place_field({4'h0, IMPL_CODE}, `CIDR_ID_IMPL_LSB);
	assign id_var_f = place_field({8'h00, VARIANT}, `CIDR_ID_VAR_LSB);
	assign id_arch_f = place_field({8'h00, ARCH_CODE}, `CIDR_ID_ARCH_LSB);
	assign id_part_f = place_field(PART_NUM, `CIDR_ID_PART_LSB);
	// Revision follows the layout actually built, set per build
	assign id_rev_f = place_field({8'h00, LAYOUT_REV}, `CIDR_ID_REV_LSB);

	// Fields never overlap, so an or assembles the constant word
	assign id_word = id_impl_f | id_var_f | id_arch_f | id_part_f | id_rev_f;

	// ------------------------------------------------------------
	// Cache geometry word
	// ------------------------------------------------------------
	wire [3:0] dsize_code;
	wire [3:0] isize_code;
	wire [11:0] dcache_desc;
	wire [11:0] icache_desc;
	wire [7:0] cache_top;
	wire [31:0] cache_word;

	assign dsize_code = DSIZE;
	assign isize_code = ISIZE;
	// Both descriptors share one layout; only the size codes differ
	assign dcache_desc = descriptor(dsize_code);
	assign icache_desc = descriptor(isize_code);
	assign cache_top = {`CIDR_TOP_RSVD, `CIDR_CTYPE, `CIDR_SEPARATE};
	assign cache_word = {cache_top, dcache_desc, icache_desc};

	// ------------------------------------------------------------
	// Memory status word
	// ------------------------------------------------------------
	wire [11:0] ipres_field;
	wire [11:0] dpres_field;
	wire [31:0] memst_ibit;
	wire [31:0] memst_dbit;
	wire [31:0] memst_word;

	// Only the two presence bits are defined; all others read zero
	assign ipres_field = {11'h000, itcm_present};
	assign dpres_field = {11'h000, dtcm_present};
	assign memst_ibit = place_field(ipres_field, `CIDR_MEMST_IPRES);
	assign memst_dbit = place_field(dpres_field, `CIDR_MEMST_DPRES);
	assign memst_word = memst_ibit | memst_dbit;

	// ------------------------------------------------------------
	// Transfer decode
	// ------------------------------------------------------------
	wire loc_hit;
	wire kind_ok;
	wire mode_ok;
	wire is_read;
	wire hit;
	wire ok_read;
	wire undef_kind;
	wire undef_mode;
	wire bad;

	// Minor selector is assumed zero by the requester and not decoded
	assign loc_hit = (xfer_major_reg == `CIDR_LOC_ZERO);
	assign kind_ok = xfer_is_reg;
	assign mode_ok = xfer_privileged;
	assign is_read = xfer_read;
	assign hit = xfer_valid && loc_hit;
	assign ok_read = hit && kind_ok && mode_ok && is_read;
	// Other instruction kinds and user-mode transfers trap, reads or writes
	assign undef_kind = hit && !kind_ok;
	assign undef_mode = hit && kind_ok && !mode_ok;
	// Privileged writes are ignored: no state changes on them
	assign bad = undef_kind || undef_mode;

	// ------------------------------------------------------------
	// Answer flags
	// ------------------------------------------------------------
	reg rdata_valid_nxt;
	reg undef_nxt;

	// Each flag pulses for one cycle, the edge after the transfer is taken
	always @* begin
		rdata_valid_nxt = 1'b0;
		undef_nxt = 1'b0;
		if (ok_read) begin
			rdata_valid_nxt = 1'b1;
		end
		if (bad) begin
			undef_nxt = 1'b1;
		end
	end

	always @(posedge mclk) begin
		if (!nrst) begin
			rdata_valid_r <= 1'b0;
			undef_r <= 1'b0;
		end else begin
			rdata_valid_r <= rdata_valid_nxt;
			undef_r <= undef_nxt;
		end
	end

	// ------------------------------------------------------------
	// Word select and read data register
	// ------------------------------------------------------------
	wire [2:0] word_sel;
	wire load_word;

	// Only an accepted read or reset (which loads zero) moves the output register,
	// so rdata holds the last word read until the next accepted read or reset
	assign word_sel = xfer_op2;
	assign load_word = ok_read;

	cidr_word_mux u_mux (
		.mclk(mclk),
		.nrst(nrst),
		.load(load_word),
		.sel(word_sel),
		.id_word(id_word),
		.cache_word(cache_word),
		.memst_word(memst_word),
		.rdata_r(rdata)
	);

endmodule

`default_nettype wire

// File: design/cidr_word_mux.v
`timescale 1ns/100ps
`default_nettype none

`include "cidr_defs.vh"

// ------------------------------------------------------------
// Registered word select
// ------------------------------------------------------------
module cidr_word_mux (
	input wire mclk,
	input wire nrst,
	input wire load,
	input wire [2:0] sel,
	input wire [31:0] id_word,
	input wire [31:0] cache_word,
	input wire [31:0] memst_word,
	output reg [31:0] rdata_r
);

	reg [31:0] rdata_nxt;

	always @* begin
		case (sel)
			`CIDR_OP2_CACHE: rdata_nxt = cache_word;
			`CIDR_OP2_MEMST: rdata_nxt = memst_word;
			default: rdata_nxt = id_word;
		endcase
	end

	always @(posedge mclk) begin
		if (!nrst) begin
			rdata_r <= `CIDR_ZERO_WORD;
		end else if (load) begin
			rdata_r <= rdata_nxt;
		end
	end

endmodule

`default_nettype wire
